// ### vpa_defs.vh
`ifndef VPA_DEFS_VH
`define VPA_DEFS_VH

// virtual port register indices (word index, byte address is 4x)
`define VPA_IDX_DIR 4'h0
`define VPA_IDX_OUT 4'h1
`define VPA_IDX_IN 4'h2
`define VPA_IDX_FLAGS 4'h3
// virtual ports spaced by this many words
`define VPA_VP_STRIDE 4'h4
// block-level registers, word index
`define VPA_IDX_MAP_LOW 5'h10
`define VPA_IDX_MAP_HIGH 5'h11
`define VPA_IDX_EVSEL 5'h12
`define VPA_IDX_IRQ_STATUS 5'h13
`define VPA_IDX_IRQ_ENABLE 5'h14
`define VPA_IDX_IRQ_CLEAR 5'h15
// per-port config areas picked by word index bits 5:4, port number in bits 3:0
`define VPA_AREA_SENSE 2'h2
`define VPA_AREA_MASK 2'h3
// field widths and reset values
`define VPA_MAP_W 4
`define VPA_EVSEL_W 3
`define VPA_FLAG_W 2
`define VPA_MAP_RST 8'h00
`define VPA_EVSEL_RST 3'h0
// input sense codes per pin: both edges, rising, falling, low level
`define VPA_SENSE_BOTH 2'h0
`define VPA_SENSE_RISE 2'h1
`define VPA_SENSE_FALL 2'h2
`define VPA_SENSE_LOW 2'h3

`endif

// ### vpa_port.v
`timescale 1ns/10ps
`include "vpa_defs.vh"

// one physical port: direction, output, synchronised input, two irq flags
module vpa_port (
    input wire clk_in,
    input wire rstn_in,
    input wire [7:0] pin_in,
    input wire wr_dir_in,
    input wire wr_out_in,
    input wire wr_flag_in,
    input wire [7:0] wdata_in,
    input wire [15:0] sense_in,
    input wire [7:0] mask0_in,
    input wire [7:0] mask1_in,
    output reg [7:0] dir_out,
    output reg [7:0] out_out,
    output reg [7:0] in_out,
    output reg [1:0] flag_out
);
    reg [7:0] meta_reg;
    reg [7:0] prev_reg;
    reg [7:0] hit;
    reg [1:0] set;
    integer i;

    // sense match on the synchronised level and its previous value
    always @* begin
        hit = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            case (sense_in[2*i +: 2])
                `VPA_SENSE_BOTH: hit[i] = in_out[i] ^ prev_reg[i];
                `VPA_SENSE_RISE: hit[i] = in_out[i] & ~prev_reg[i];
                `VPA_SENSE_FALL: hit[i] = ~in_out[i] & prev_reg[i];
                default: hit[i] = ~in_out[i];
            endcase
        end
        set = {|(hit & mask1_in), |(hit & mask0_in)};
    end

    // pin sync, registers; a set in the clearing cycle wins
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= 8'h00;
            in_out <= 8'h00;
            prev_reg <= 8'h00;
            dir_out <= 8'h00;
            out_out <= 8'h00;
            flag_out <= 2'h0;
        end else begin
            meta_reg <= pin_in;
            in_out <= meta_reg;
            prev_reg <= in_out;
            if (wr_dir_in)
                dir_out <= wdata_in;
            if (wr_out_in)
                out_out <= wdata_in;
            if (wr_flag_in)
                flag_out <= (flag_out & ~wdata_in[1:0]) | set;
            else
                flag_out <= flag_out | set;
        end
    end
endmodule // vpa_port

// ### vpa_top.v
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "vpa_defs.vh"

module vpa_top #(
    parameter NPORT = 16,
    parameter NVP = 4
) (
    input wire REF_CLK_IN,
    input wire RESETN_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [7:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output wire PREADY_OUT,
    output wire PSLVERR_OUT,
    input wire [8*NPORT-1:0] PORT_PIN_IN,
    output wire [8*NPORT-1:0] PORT_DIR_OUT,
    output wire [8*NPORT-1:0] PORT_OUT_OUT,
    input wire [7:0] EVENT_CH_IN,
    output reg EVENT_PIN_OUT,
    output wire IRQ_OUT
);
    wire [8*NPORT-1:0] in_all;
    wire [2*NPORT-1:0] flag_all;
    reg [7:0] map_low_reg;
    reg [7:0] map_high_reg;
    reg [2:0] evsel_reg;
    reg [7:0] ev_meta_reg;
    reg [7:0] ev_sync_reg;
    reg [15:0] sense_reg [0:NPORT-1];
    reg [7:0] mask0_reg [0:NPORT-1];
    reg [7:0] mask1_reg [0:NPORT-1];
    reg [NVP-1:0] irq_status_reg;
    reg [NVP-1:0] irq_enable_reg;
    reg [NVP-1:0] vp_flag_prev_reg;
    reg [3:0] vp_map [0:NVP-1];
    reg [NPORT-1:0] wr_dir;
    reg [NPORT-1:0] wr_out;
    reg [NPORT-1:0] wr_flag;
    reg [NVP-1:0] vp_flag_any;
    reg [31:0] rdata_next;
    reg addr_ok;
    wire acc;
    wire wr;
    wire [5:0] idx;
    wire vp_area;
    wire [1:0] vp_num;
    wire [1:0] vp_reg;
    integer k;
    integer m;

    // zero-wait slave: every access completes in its first access cycle
    assign acc = PSEL_IN & PENABLE_IN;
    assign wr = acc & PWRITE_IN;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = acc & ~addr_ok;
    assign idx = PADDR_IN[7:2];
    assign vp_area = (idx[5:4] == 2'b00);
    assign vp_num = idx[3:2];
    assign vp_reg = idx[1:0];

    // unpack selectors, lower virtual port in the low nibble
    always @* begin
        vp_map[0] = map_low_reg[3:0];
        vp_map[1] = map_low_reg[7:4];
        vp_map[2] = map_high_reg[3:0];
        vp_map[3] = map_high_reg[7:4];
    end

    // physical ports, one instance each
    genvar g;
    generate
        for (g = 0; g < NPORT; g = g + 1) begin : gen_port
            vpa_port u_port (
                .clk_in(REF_CLK_IN),
                .rstn_in(RESETN_IN),
                .pin_in(PORT_PIN_IN[8*g +: 8]),
                .wr_dir_in(wr_dir[g]),
                .wr_out_in(wr_out[g]),
                .wr_flag_in(wr_flag[g]),
                .wdata_in(PWDATA_IN[7:0]),
                .sense_in(sense_reg[g]),
                .mask0_in(mask0_reg[g]),
                .mask1_in(mask1_reg[g]),
                .dir_out(PORT_DIR_OUT[8*g +: 8]),
                .out_out(PORT_OUT_OUT[8*g +: 8]),
                .in_out(in_all[8*g +: 8]),
                .flag_out(flag_all[2*g +: 2])
            );
        end
    endgenerate

    // write strobes: a virtual write lands on the selected port itself
    always @* begin
        wr_dir = {NPORT{1'b0}};
        wr_out = {NPORT{1'b0}};
        wr_flag = {NPORT{1'b0}};
        if (wr && vp_area) begin
            case (vp_reg)
                2'd0: wr_dir[vp_map[vp_num]] = 1'b1;
                2'd1: wr_out[vp_map[vp_num]] = 1'b1;
                2'd3: wr_flag[vp_map[vp_num]] = 1'b1;
                default: ;
            endcase
        end
    end

    // read mux, only four aliased registers per virtual port
    always @* begin
        rdata_next = 32'h00000000;
        addr_ok = 1'b1;
        if (vp_area) begin
            case (vp_reg)
                2'd0: rdata_next[7:0] = PORT_DIR_OUT[8*vp_map[vp_num] +: 8];
                2'd1: rdata_next[7:0] = PORT_OUT_OUT[8*vp_map[vp_num] +: 8];
                2'd2: rdata_next[7:0] = in_all[8*vp_map[vp_num] +: 8];
                default: rdata_next[1:0] = flag_all[2*vp_map[vp_num] +: 2];
            endcase
        end else if (idx[5:4] == `VPA_AREA_SENSE) begin
            // per-port sense codes, one word per port so every port is reachable
            rdata_next[15:0] = sense_reg[idx[3:0]];
        end else if (idx[5:4] == `VPA_AREA_MASK) begin
            // flag 1 sources in the upper byte, flag 0 sources in the lower
            rdata_next[15:0] = {mask1_reg[idx[3:0]], mask0_reg[idx[3:0]]};
        end else begin
            case ({1'b1, idx[3:0]})
                `VPA_IDX_MAP_LOW: rdata_next[7:0] = map_low_reg;
                `VPA_IDX_MAP_HIGH: rdata_next[7:0] = map_high_reg;
                `VPA_IDX_EVSEL: rdata_next[2:0] = evsel_reg;
                `VPA_IDX_IRQ_STATUS: rdata_next[NVP-1:0] = irq_status_reg;
                `VPA_IDX_IRQ_ENABLE: rdata_next[NVP-1:0] = irq_enable_reg;
                `VPA_IDX_IRQ_CLEAR: rdata_next = 32'h00000000;
                default: addr_ok = 1'b0;
            endcase
        end
        if (!addr_ok)
            rdata_next = 32'h00000000;
    end

    // any flag of the port mapped to each virtual port
    always @* begin
        for (k = 0; k < NVP; k = k + 1)
            vp_flag_any[k] = |flag_all[2*vp_map[k] +: 2];
    end

    // configuration and read data registers
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            map_low_reg <= `VPA_MAP_RST;
            map_high_reg <= `VPA_MAP_RST;
            evsel_reg <= `VPA_EVSEL_RST;
            irq_enable_reg <= {NVP{1'b0}};
            PRDATA_OUT <= 32'h00000000;
            for (m = 0; m < NPORT; m = m + 1) begin
                sense_reg[m] <= 16'h0000;
                mask0_reg[m] <= 8'h00;
                mask1_reg[m] <= 8'h00;
            end
        end else begin
            // loaded in the setup cycle so it stands at the completing edge
            if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
                PRDATA_OUT <= rdata_next;
            if (wr && idx == {1'b0, `VPA_IDX_MAP_LOW})
                map_low_reg <= PWDATA_IN[7:0];
            if (wr && idx == {1'b0, `VPA_IDX_MAP_HIGH})
                map_high_reg <= PWDATA_IN[7:0];
            if (wr && idx == {1'b0, `VPA_IDX_EVSEL})
                evsel_reg <= PWDATA_IN[2:0];
            if (wr && idx == {1'b0, `VPA_IDX_IRQ_ENABLE})
                irq_enable_reg <= PWDATA_IN[NVP-1:0];
            if (wr && idx[5:4] == `VPA_AREA_SENSE)
                sense_reg[idx[3:0]] <= PWDATA_IN[15:0];
            if (wr && idx[5:4] == `VPA_AREA_MASK) begin
                mask0_reg[idx[3:0]] <= PWDATA_IN[7:0];
                mask1_reg[idx[3:0]] <= PWDATA_IN[15:8];
            end
        end
    end

    // sticky status on rising mapped-flag summary; set beats clear
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            irq_status_reg <= {NVP{1'b0}};
            vp_flag_prev_reg <= {NVP{1'b0}};
        end else begin
            vp_flag_prev_reg <= vp_flag_any;
            if (wr && idx == {1'b0, `VPA_IDX_IRQ_CLEAR})
                irq_status_reg <= (irq_status_reg & ~PWDATA_IN[NVP-1:0])
                    | (vp_flag_any & ~vp_flag_prev_reg);
            else
                irq_status_reg <= irq_status_reg | (vp_flag_any & ~vp_flag_prev_reg);
        end
    end

    assign IRQ_OUT = |(irq_status_reg & irq_enable_reg);

    // event channels come from another block: synchronise, then select
    always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ev_meta_reg <= 8'h00;
            ev_sync_reg <= 8'h00;
            EVENT_PIN_OUT <= 1'b0;
        end else begin
            ev_meta_reg <= EVENT_CH_IN;
            ev_sync_reg <= ev_meta_reg;
            EVENT_PIN_OUT <= ev_sync_reg[evsel_reg];
        end
    end
endmodule // vpa_top

// ### vpa_top_monitor.sv
`timescale 1ns/10ps
// protocol and alias checks seen from the block's pins only
module vpa_top_monitor #(parameter NPORT = 16) (
    input wire logic REF_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic [8*NPORT-1:0] PORT_DIR_OUT,
    input wire logic [8*NPORT-1:0] PORT_OUT_OUT,
    input wire logic [7:0] EVENT_CH_IN,
    input wire logic EVENT_PIN_OUT,
    input wire logic IRQ_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // zero-wait slave; error only inside an access
    property p_ready; PREADY_OUT; endproperty
    a_ready: assert property (p_ready) else $error("ready dropped");
    property p_err; PSLVERR_OUT |-> PSEL_IN && PENABLE_IN; endproperty
    a_err: assert property (p_err) else $error("error outside access");
    // all channels equal: any selection must follow after three edges
    property p_ev1; (EVENT_CH_IN == 8'hff) [*4] |-> EVENT_PIN_OUT; endproperty
    a_ev1: assert property (p_ev1) else $error("event pin stuck low");
    property p_ev0; (EVENT_CH_IN == 8'h00) [*4] |-> !EVENT_PIN_OUT; endproperty
    a_ev0: assert property (p_ev0) else $error("event pin stuck high");
    // port registers move only after a bus write
    property p_dir; $changed(PORT_DIR_OUT) |-> $past(PSEL_IN && PENABLE_IN && PWRITE_IN);
    endproperty
    a_dir: assert property (p_dir) else $error("direction changed alone");
    property p_out; $changed(PORT_OUT_OUT) |-> $past(PSEL_IN && PENABLE_IN && PWRITE_IN);
    endproperty
    a_out: assert property (p_out) else $error("output changed alone");
    property p_flg;
        PSEL_IN && PENABLE_IN && !PWRITE_IN && PADDR_IN < 8'h40 && PADDR_IN[3:2] == 2'h3
        |-> PRDATA_OUT[31:2] == 30'h0;
    endproperty
    a_flg: assert property (p_flg) else $error("flag upper bits set");
    property p_irq; $fell(IRQ_OUT) |-> $past(PSEL_IN && PENABLE_IN && PWRITE_IN); endproperty
    a_irq: assert property (p_irq) else $error("irq fell without write");
    // read data loads only in a read's setup cycle
    property p_rd; $changed(PRDATA_OUT) |-> $past(PSEL_IN && !PENABLE_IN && !PWRITE_IN);
    endproperty
    a_rd: assert property (p_rd) else $error("read data moved alone");
endmodule // vpa_top_monitor

bind vpa_top vpa_top_monitor #(.NPORT(NPORT)) i_mon (.REF_CLK_IN(REF_CLK_IN),
    .RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
    .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .PORT_DIR_OUT(PORT_DIR_OUT), .PORT_OUT_OUT(PORT_OUT_OUT),
    .EVENT_CH_IN(EVENT_CH_IN), .EVENT_PIN_OUT(EVENT_PIN_OUT), .IRQ_OUT(IRQ_OUT));

// ### vpa_pad_model.sv
`timescale 1ns/10ps
// external pads: a pin set as output reads back its own level
module vpa_pad_model #(parameter NPORT = 16) (
    input wire logic [8*NPORT-1:0] dir_in,
    input wire logic [8*NPORT-1:0] out_in,
    input wire logic [8*NPORT-1:0] ext_in,
    output wire logic [8*NPORT-1:0] pin_out
);
    // outputs win over the outside world, never a floating level
    assign pin_out = (dir_in & out_in) | (~dir_in & ext_in);
endmodule // vpa_pad_model

// ### vpa_top_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module vpa_top_test;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, se;
    logic [7:0] paddr = 8'h00, ev = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, evpin, irq;
    logic [127:0] ext, pin, dir, out;
    integer error_cnt = 0, n_compared = 0, i;
    // 25 MHz clock
    always #20 clk = ~clk;
    vpa_pad_model i_pad (.dir_in(dir), .out_in(out), .ext_in(ext), .pin_out(pin));
    vpa_top i_dut (.REF_CLK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PORT_PIN_IN(pin), .PORT_DIR_OUT(dir),
        .PORT_OUT_OUT(out), .EVENT_CH_IN(ev), .EVENT_PIN_OUT(evpin), .IRQ_OUT(irq));
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one apb transfer; data and error taken at the edge that sees ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer k;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k >= 16) begin
            error_cnt++;
            complete_run;
        end
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // hang guard
    initial begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        complete_run;
    end
    // main sequence
    initial begin
        for (i = 0; i < 16; i++) ext[8*i+:8] = {i[3:0], ~i[3:0]};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdchk(8'h40, 32'h0);
        rdchk(8'h48, 32'h0);
        `CHK(irq, 1'b0)
        wr(8'h40, 32'h12);
        wr(8'h44, 32'hf0);
        rdchk(8'h40, 32'h12);
        rdchk(8'h44, 32'hf0);
        rdchk(8'h08, 32'h2d);
        rdchk(8'h38, 32'hf0);
        rdchk(8'h28, 32'h0f);
        $display("test map done");
        wr(8'h00, 32'ha5);
        `CHK(dir[23:16], 8'ha5)
        wr(8'h30, 32'h81);
        `CHK(dir[127:120], 8'h81)
        rdchk(8'h30, 32'h81);
        wr(8'h14, 32'h3c);
        `CHK(out[15:8], 8'h3c)
        rdchk(8'h14, 32'h3c);
        repeat (3) @(posedge clk);
        rdchk(8'h08, {24'h0, 8'h2d & ~8'ha5});
        $display("test alias done");
        // every port: pin0 feeds flag 0, pin1 feeds flag 1; port1 pin0 senses rising edges
        for (i = 0; i < 16; i++) wr({2'b11, i[3:0], 2'b00}, 32'h0201);
        wr(8'h84, 32'h1);
        wr(8'h50, 32'h3);
        ext[8] <= 1'b1;
        repeat (6) @(posedge clk);
        rdchk(8'h1c, 32'h1);
        `CHK(irq, 1'b1)
        wr(8'h1c, 32'h2);
        rdchk(8'h1c, 32'h1);
        wr(8'h1c, 32'h1);
        rdchk(8'h1c, 32'h0);
        ext[17] <= 1'b1;
        repeat (6) @(posedge clk);
        rdchk(8'h0c, 32'h2);
        wr(8'h0c, 32'h2);
        rdchk(8'h0c, 32'h0);
        rdchk(8'h4c, 32'h3);
        wr(8'h50, 32'h0);
        `CHK(irq, 1'b0)
        wr(8'h50, 32'h3);
        `CHK(irq, 1'b1)
        wr(8'h54, 32'h3);
        `CHK(irq, 1'b0)
        rdchk(8'h4c, 32'h0);
        // falling edge sense, then low level keeps the flag set through a clear
        wr(8'h84, 32'h2);
        ext[8] <= 1'b0;
        repeat (6) @(posedge clk);
        rdchk(8'h1c, 32'h1);
        wr(8'h84, 32'h3);
        wr(8'h1c, 32'h1);
        rdchk(8'h1c, 32'h1);
        $display("test flags done");
        // each code routes its own channel only
        for (i = 0; i < 8; i++) begin
            wr(8'h48, i);
            ev <= 8'h01 << i;
            repeat (4) @(posedge clk);
            `CHK(evpin, 1'b1)
            ev <= ~(8'h01 << i);
            repeat (4) @(posedge clk);
            `CHK(evpin, 1'b0)
        end
        ev <= 8'hff;
        repeat (5) @(posedge clk);
        `CHK(evpin, 1'b1)
        ev <= 8'h00;
        rdchk(8'h48, 32'h7);
        rdchk(8'h58, 32'h0);
        `CHK(se, 1'b1)
        $display("test event done");
        complete_run;
    end
endmodule // vpa_top_test
